// ### inc/rscp_pkg.sv
// rscp_pkg: constants of the radio serial control port.
// assumes a 24-bit control word with a 3-bit latch address on top.
package rscp_pkg;
   localparam int WORD_W = 24;
   localparam int ADDR_W = 3;
   localparam int FIELD_W = WORD_W - ADDR_W;
   localparam int FREQ_W = 22;
   localparam int FUNC_W = 13;
   localparam int DEV_W = 8;
   localparam int ACQ_W = 3;
   localparam int ATT_W = 5;

   // latch addresses
   localparam logic [2:0] ADDR_FREQ0 = 3'h0;
   localparam logic [2:0] ADDR_FREQ1 = 3'h1;
   localparam logic [2:0] ADDR_CFG = 3'h2;
   localparam logic [2:0] ADDR_MODE0 = 3'h3;
   localparam logic [2:0] ADDR_MODE1 = 3'h4;
   localparam logic [2:0] ADDR_TEST = 3'h7;

   // field positions inside the 21-bit latch content
   localparam int LNA_LSB = 0;
   localparam int MIX_BIT = 2;
   localparam int IFAMP_BIT = 3;
   localparam int LIM_BIT = 4;
   localparam int RSSI_BIT = 5;
   localparam int ROUTE_BIT = 6;
   localparam int LPF_BIT = 7;
   localparam int SLC_BIT = 8;
   localparam int AMP_LSB = 9;
   localparam int OSC_BIT = 11;
   localparam int LOOP_BIT = 12;
   localparam int DEV_LSB = 13;
   localparam int MODM_BIT = 16;
   localparam int DIV_BIT = 17;
   localparam int ACQ_LSB = 18;

   // codes
   localparam logic [1:0] LNA_ON = 2'h3;
   localparam logic [1:0] AMP_OFF = 2'h0;
   localparam logic [1:0] AMP_ATT10 = 2'h1;
   localparam logic [1:0] AMP_ATT20 = 2'h2;
   localparam logic [1:0] AMP_ATT0 = 2'h3;
   localparam logic [4:0] ATT_10DB = 5'h0a;
   localparam logic [4:0] ATT_20DB = 5'h14;
   localparam logic [4:0] ATT_0DB = 5'h00;

   // power-up value of every latch
   localparam logic [20:0] LATCH_RST = 21'h000000;
endpackage : rscp_pkg

// ### inc/rscp_word_if.sv
// rscp_word_if: a received control word and its load pulse.
// assumes both ends run on clk_sys.
`timescale 1ns/10ps
interface rscp_word_if;
   logic [23:0] word;
   logic load;
   modport src (output word, output load);
   modport dst (input word, input load);
endinterface : rscp_word_if

// ### core/rscp_shifter.sv
// rscp_shifter: samples the three serial pins and assembles words.
// assumes clk_sys runs several times faster than the serial clock.
`timescale 1ns/10ps
module rscp_shifter
   import rscp_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic reset_n,
   // serial pins
   input wire logic serClk,
   input wire logic serData,
   input wire logic serStrobe,
   // received words
   rscp_word_if.src wordBus
);
   logic [2:0] clkSync_r;
   logic [1:0] dataSync_r;
   logic [2:0] strobeSync_r;
   logic [WORD_W-1:0] shift_r;
   logic [WORD_W-1:0] word_r;
   logic load_r;
   wire clkRise = clkSync_r[1] & ~clkSync_r[2];
   wire strobeRise = strobeSync_r[1] & ~strobeSync_r[2];
   // clock edges while the strobe is up are stray; the host keeps them low
   wire shiftEn = clkRise & ~strobeSync_r[1];

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         clkSync_r <= 3'h0;
         dataSync_r <= 2'h0;
         strobeSync_r <= 3'h0;
      end
      else
      begin
         clkSync_r <= {clkSync_r[1:0], serClk};
         dataSync_r <= {dataSync_r[0], serData};
         strobeSync_r <= {strobeSync_r[1:0], serStrobe};
      end
   end

   // older bits fall off the top, so only the last 24 survive
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         shift_r <= 24'h000000;
      else if (shiftEn)
         shift_r <= {shift_r[WORD_W-2:0], dataSync_r[1]};
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         word_r <= 24'h000000;
         load_r <= 1'b0;
      end
      else
      begin
         load_r <= strobeRise;
         if (strobeRise)
            word_r <= shift_r;
      end
   end

   assign wordBus.word = word_r;
   assign wordBus.load = load_r;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   shift_lsb_a: assert property (shiftEn |=>
      shift_r[0] == $past(dataSync_r[1])
      && shift_r[WORD_W-1:1] == $past(shift_r[WORD_W-2:0]))
      else $error("serial bit not shifted in");
   load_pulse_a: assert property (strobeRise |=>
      load_r && word_r == $past(shift_r) ##1 !load_r)
      else $error("load pulse wrong");
endmodule : rscp_shifter

// ### core/rscp_port.sv
// rscp_port: latches and mode-0/mode-1 decode of the serial control port.
// assumes the serial pins come straight from an off-chip host.
`timescale 1ns/10ps
// Functional notes
// - sample data on each serial clock rise while strobe is low
// - strobe rise loads word into addressed latch
// - only the last 24 bits are kept
// - port works in active and standby alike
// - address 111 nonzero enters test mode
// - test mode ends on power-up or zero write
// - C word picks divider 256 or 512
// - amplifier level sits in bits 10:9
// - amp codes: off, 10dB, 20dB, 0dB
// - low-noise amp on only for code 11
// - single enable bits: one on, zero off
// - route bit: demodulator or signal strength
// - loop bit powers the loop only; oscillator has its own bit
// - mode pin chooses mode-0 or mode-1 settings
// - demodulator auto-on with limiter, lowpass, route bit zero
module rscp_port
   import rscp_pkg::*;
#(
   parameter int WordBits = WORD_W
)
(
   // system
   input wire logic clk_sys,
   input wire logic reset_n,
   // serial pins
   input wire logic serClk,
   input wire logic serData,
   input wire logic serStrobe,
   // mode select pin
   input wire logic modeSelect,
   // receive chain
   output logic lnaEnable,
   output logic mixerEnable,
   output logic ifAmpEnable,
   output logic limiterEnable,
   output logic signalStrengthEnable,
   output logic dataRouteSelect,
   output logic lowpassAmpEnable,
   output logic slicerEnable,
   output logic demodEnable,
   // transmit and synthesizer
   output logic ampEnable,
   output logic [ATT_W-1:0] ampAttenDb,
   output logic oscillatorEnable,
   output logic loopEnable,
   output logic [FREQ_W-1:0] activeFreq,
   output logic [DEV_W-1:0] deviation,
   output logic divideBy512,
   output logic fskModOff,
   output logic [ACQ_W-1:0] acquisitionGain,
   // test
   output logic testMode
);
   if (WordBits != WORD_W)
   begin : g_badWidth
      $error("control word must be 24 bits");
   end

   rscp_word_if wordBus ();

   // synchronisers and shifting stay free-running: standby never gates them
   rscp_shifter u_shifter (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .serClk(serClk),
      .serData(serData),
      .serStrobe(serStrobe),
      .wordBus(wordBus)
   );

   function automatic logic hitLatch(input logic [2:0] a,
                                     input logic [2:0] code);
      hitLatch = (a == code);
   endfunction : hitLatch

   function automatic logic [4:0] attenFor(input logic [1:0] lvl);
      case (lvl)
         AMP_ATT10: attenFor = ATT_10DB;
         AMP_ATT20: attenFor = ATT_20DB;
         AMP_ATT0: attenFor = ATT_0DB;
         default: attenFor = ATT_0DB;
      endcase
   endfunction : attenFor

   logic [1:0] modeSync_r;
   logic [FREQ_W-1:0] freq0_r;
   logic [FREQ_W-1:0] freq1_r;
   logic [FIELD_W-1:0] cfg_r;
   logic [FUNC_W-1:0] mode0FunctionEnables_r;
   logic [FUNC_W-1:0] mode1FunctionEnables_r;
   logic [DEV_W-1:0] dev_r;
   logic [FIELD_W-1:0] test_r;

   // first received bit is bit 23, so the address is the top three
   wire [ADDR_W-1:0] addr = wordBus.word[WORD_W-1:FIELD_W];
   wire [FIELD_W-1:0] content = wordBus.word[FIELD_W-1:0];
   wire wrFreq0 = wordBus.load & hitLatch(addr, ADDR_FREQ0);
   wire wrFreq1 = wordBus.load & hitLatch(addr, ADDR_FREQ1);
   wire wrCfg = wordBus.load & hitLatch(addr, ADDR_CFG);
   wire wrMode0 = wordBus.load & hitLatch(addr, ADDR_MODE0);
   wire wrMode1 = wordBus.load & hitLatch(addr, ADDR_MODE1);
   wire wrTest = wordBus.load & hitLatch(addr, ADDR_TEST);

   // reset_n stands in for power-up; every latch comes up zero
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         freq0_r <= 22'h000000;
         freq1_r <= 22'h000000;
         cfg_r <= LATCH_RST;
         mode0FunctionEnables_r <= 13'h0000;
         mode1FunctionEnables_r <= 13'h0000;
         dev_r <= 8'h00;
         test_r <= LATCH_RST;
      end
      else
      begin
         // word bit 21 is an address bit, so frequency bit 21 reads zero
         if (wrFreq0)
            freq0_r <= FREQ_W'(content);
         if (wrFreq1)
            freq1_r <= FREQ_W'(content);
         if (wrCfg)
            cfg_r <= content;
         if (wrMode0)
         begin
            mode0FunctionEnables_r <= content[FUNC_W-1:0];
            dev_r <= content[DEV_LSB+DEV_W-1:DEV_LSB];
         end
         if (wrMode1)
            mode1FunctionEnables_r <= content[FUNC_W-1:0];
         // only an all-zero write to this latch leaves test mode
         if (wrTest)
            test_r <= content;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         modeSync_r <= 2'h0;
      else
         modeSync_r <= {modeSync_r[0], modeSelect};
   end

   wire [FUNC_W-1:0] fn = modeSync_r[1] ? mode1FunctionEnables_r
                                        : mode0FunctionEnables_r;
   wire [FREQ_W-1:0] freqSel = modeSync_r[1] ? freq1_r : freq0_r;
   wire [1:0] ampLvl = fn[AMP_LSB+1:AMP_LSB];
   wire lnaNxt = (fn[LNA_LSB+1:LNA_LSB] == LNA_ON);
   wire ampNxt = (ampLvl != AMP_OFF);
   wire demodNxt = fn[LIM_BIT] & fn[LPF_BIT] & ~fn[ROUTE_BIT];

   // outputs all leave from flops, one cycle behind the latches
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lnaEnable <= 1'b0;
         mixerEnable <= 1'b0;
         ifAmpEnable <= 1'b0;
         limiterEnable <= 1'b0;
         signalStrengthEnable <= 1'b0;
         dataRouteSelect <= 1'b0;
         lowpassAmpEnable <= 1'b0;
         slicerEnable <= 1'b0;
         demodEnable <= 1'b0;
         ampEnable <= 1'b0;
         ampAttenDb <= 5'h00;
         oscillatorEnable <= 1'b0;
         loopEnable <= 1'b0;
         activeFreq <= 22'h000000;
         deviation <= 8'h00;
         divideBy512 <= 1'b0;
         fskModOff <= 1'b0;
         acquisitionGain <= 3'h0;
         testMode <= 1'b0;
      end
      else
      begin
         lnaEnable <= lnaNxt;
         mixerEnable <= fn[MIX_BIT];
         ifAmpEnable <= fn[IFAMP_BIT];
         limiterEnable <= fn[LIM_BIT];
         signalStrengthEnable <= fn[RSSI_BIT];
         dataRouteSelect <= fn[ROUTE_BIT];
         lowpassAmpEnable <= fn[LPF_BIT];
         slicerEnable <= fn[SLC_BIT];
         demodEnable <= demodNxt;
         ampEnable <= ampNxt;
         ampAttenDb <= attenFor(ampLvl);
         oscillatorEnable <= fn[OSC_BIT];
         loopEnable <= fn[LOOP_BIT];
         activeFreq <= freqSel;
         deviation <= dev_r;
         divideBy512 <= cfg_r[DIV_BIT];
         fskModOff <= cfg_r[MODM_BIT];
         acquisitionGain <= cfg_r[ACQ_LSB+ACQ_W-1:ACQ_LSB];
         testMode <= |test_r;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   mode0_load_a: assert property (wrMode0 |=>
      mode0FunctionEnables_r == $past(wordBus.word[FUNC_W-1:0])
      && dev_r == $past(wordBus.word[DEV_LSB+DEV_W-1:DEV_LSB]))
      else $error("mode-0 word not latched");
   test_entry_a: assert property ((wrTest && |content) |=> ##1 testMode)
      else $error("test mode not entered");
   test_exit_a: assert property ((wrTest && content == 21'h000000)
      |=> ##1 !testMode)
      else $error("test mode not left on zero write");
   // a clearing write one cycle back still shows testMode high here
   test_hold_a: assert property ((testMode && !wrTest
      && !$past(wrTest)) |=> ##1 testMode)
      else $error("test mode left without zero write");
   lna_code_a: assert property (lnaEnable
      |-> $past(fn[LNA_LSB+1:LNA_LSB]) == LNA_ON)
      else $error("low-noise amp on with wrong code");
   amp_level_a: assert property (ampEnable == ($past(ampLvl) != AMP_OFF)
      && (!ampEnable || ampAttenDb == attenFor($past(ampLvl))))
      else $error("amplifier level decode wrong");
   demod_auto_a: assert property (demodEnable == (limiterEnable
      && lowpassAmpEnable && !dataRouteSelect))
      else $error("demodulator enable wrong");
   divider_pick_a: assert property (wrCfg |=> ##1
      divideBy512 == $past(wordBus.word[DIV_BIT], 2))
      else $error("divider select not applied");
   mode_pick_a: assert property ($stable(modeSync_r[1]) && modeSync_r[1]
      |=> activeFreq == $past(freq1_r))
      else $error("mode-1 frequency not applied");
endmodule : rscp_port

// ### tb/rscp_host_model.sv
// rscp_host_model: host side of the three-wire serial port.
// assumes clk_sys at 50 ns; serial clock is 8 clk_sys, 400 ns.
`timescale 1ns/10ps
module rscp_host_model
(
   // system
   input wire logic clk_sys,
   // serial pins
   output logic serClk,
   output logic serData,
   output logic serStrobe
);
   initial
   begin
      serClk = 1'b0;
      serData = 1'b0;
      serStrobe = 1'b0;
   end
   task wt(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : wt
   // one whole 24-bit word per call
   task send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--)
      begin
         serData = w[i];
         wt(4);
         serClk = 1'b1;
         wt(4);
         serClk = 1'b0;
      end
   endtask : send
   task load();
      serData = 1'b0;
      wt(2);
      serStrobe = 1'b1;
      wt(4);
      serStrobe = 1'b0;
      // idle data is not left at its last value
      serData = 1'b1;
      wt(4);
   endtask : load
endmodule : rscp_host_model

// ### tb/test_radio_serial_control_port.sv
// test_radio_serial_control_port: self-checking bench of rscp_port.
// assumes rscp_host_model drives the pins; outputs settle in 5 clk_sys.
`timescale 1ns/10ps
module test_radio_serial_control_port;
   import rscp_pkg::*;
   typedef struct packed {
      logic [23:0] word;
      logic [11:0] en;
      logic [4:0] att;
   } rscp_row_t;
   logic clk_sys, reset_n, serClk, serData, serStrobe, modeSelect;
   logic lna, mix, ifa, lim, rssi, route, lpf, slc, demod, amp, osc, loop;
   logic [ATT_W-1:0] ampAttenDb;
   logic [FREQ_W-1:0] activeFreq;
   logic [DEV_W-1:0] deviation;
   logic [ACQ_W-1:0] acquisitionGain;
   logic divideBy512, fskModOff, testMode;
   logic [11:0] enObs;
   int fail_count, samples_checked;
   rscp_row_t rows [5];
   assign enObs = {lna, mix, ifa, lim, rssi, route, lpf, slc, demod, amp,
      osc, loop};
   rscp_port rscp_port_i (.clk_sys(clk_sys),
      .reset_n(reset_n), .serClk(serClk), .serData(serData),
      .serStrobe(serStrobe), .modeSelect(modeSelect), .lnaEnable(lna),
      .mixerEnable(mix), .ifAmpEnable(ifa), .limiterEnable(lim),
      .signalStrengthEnable(rssi), .dataRouteSelect(route),
      .lowpassAmpEnable(lpf), .slicerEnable(slc), .demodEnable(demod),
      .ampEnable(amp), .ampAttenDb(ampAttenDb), .oscillatorEnable(osc),
      .loopEnable(loop), .activeFreq(activeFreq), .deviation(deviation),
      .divideBy512(divideBy512), .fskModOff(fskModOff),
      .acquisitionGain(acquisitionGain), .testMode(testMode));
   rscp_host_model rscp_host_model_i (.clk_sys(clk_sys), .serClk(serClk),
      .serData(serData), .serStrobe(serStrobe));
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task put(input logic [23:0] w);
      rscp_host_model_i.send(w);
      rscp_host_model_i.load();
   endtask : put
   task close_out();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   initial
   begin
      #2000000;
      fail_count++;
      $display("[ERR] %0t run limit reached", $time);
      close_out();
   end
   initial
   begin
      reset_n = 1'b0;
      modeSelect = 1'b0;
      fail_count = 0;
      samples_checked = 0;
      // word, expected enables, expected attenuation
      rows[0] = '{24'h600a01, 12'h006, 5'h0a};
      rows[1] = '{24'h600c02, 12'h006, 5'h14};
      rows[2] = '{24'h74bfbf, 12'hfbf, 5'h00};
      rows[3] = '{24'h601fff, 12'hff7, 5'h00};
      rows[4] = '{24'h600890, 12'h12a, 5'h00};
      repeat (2) @(posedge clk_sys);
      #2 reset_n = 1'b1;
      chk({enObs, ampAttenDb, testMode}, '0, "reset enables");
      chk({activeFreq, divideBy512}, '0, "reset freq");
      rscp_host_model_i.wt(3);
      put(24'he00000);
      chk(testMode, 1'b0, "test cleared");
      $display("test reset done");
      // osc bit kept set in the working rows
      for (int i = 0; i < 5; i++)
      begin
         put(rows[i].word);
         chk(enObs, rows[i].en, "enables");
         chk(enObs, rows[i].en, "route demod");
         chk(ampAttenDb, rows[i].att, "amp level");
         chk(deviation, rows[i].word[20:13], "deviation");
      end
      $display("test mode0 table done");
      // 48 bits before one strobe: the first word must be dropped
      rscp_host_model_i.send(24'h5a5a5a);
      put(24'h1234ab);
      chk(activeFreq, 22'h1234ab, "overlong");
      put(24'h570000);
      chk({divideBy512, fskModOff, acquisitionGain}, 5'h1d, "c");
      put(24'h400000);
      chk({divideBy512, fskModOff, acquisitionGain}, 5'h00, "c");
      put(24'ha01fff);
      chk(enObs, rows[4].en, "unused address");
      $display("test words done");
      put(24'h800003);
      put(24'h2abcde);
      chk(enObs, rows[4].en, "mode1 hidden");
      modeSelect = 1'b1;
      rscp_host_model_i.wt(6);
      chk(enObs, 12'h800, "mode1 shown");
      chk(activeFreq, 22'h0abcde, "mode1 freq");
      modeSelect = 1'b0;
      rscp_host_model_i.wt(6);
      chk(enObs, rows[4].en, "mode0 back");
      chk(activeFreq, 22'h1234ab, "mode0 freq");
      $display("test mode select done");
      put(24'he00001);
      chk(testMode, 1'b1, "test set");
      put(24'h000000);
      chk(testMode, 1'b1, "test held");
      put(24'he00000);
      chk(testMode, 1'b0, "test zero write");
      put(24'hf00000);
      chk(testMode, 1'b1, "test set high bit");
      // a second power-up leaves test mode and zeroes the latches
      reset_n = 1'b0;
      rscp_host_model_i.wt(2);
      chk({enObs, testMode}, '0, "second reset");
      chk(activeFreq, '0, "second reset freq");
      reset_n = 1'b1;
      rscp_host_model_i.wt(3);
      put(24'h600003);
      chk(enObs, 12'h800, "after reset");
      $display("test mode latch done");
      close_out();
   end
endmodule : test_radio_serial_control_port
